// file: efc_regs.svh
`ifndef EFC_REGS_SVH
`define EFC_REGS_SVH
// Purpose: timing counts for the earth-fault coordination block
// Assumes: 250 MHz clock, 1 ms tick
// Notes: times in ms, derived cycle counts
`define EFC_CLK_KHZ 250000
`define EFC_TICK_MS 1
`define EFC_TICK_CYC (`EFC_CLK_KHZ * `EFC_TICK_MS)
`define EFC_WINDOW_MS 1000
`define EFC_FAST_BLK_MS 400
`define EFC_FULL_BLK_MS 1000
`define EFC_MIN_PULSES 6
`define EFC_UN_LOW 8'h64
`define EFC_UN_HIGH 8'h6E
`endif

// file: efc_pkg.sv
// Purpose: types for the earth-fault coordination block
// Assumes: none
// Notes: one state enum shared by the transient and intermittent stages
package efc_pkg;
    typedef logic [15:0] efc_ms_t;
    typedef enum logic [1:0] {EFC_IDLE, EFC_RUN, EFC_DONE} efc_st_e;
    typedef struct packed {
        logic [17:0] tick_cnt;
        logic tick;
        efc_st_e tr_st;
        logic [15:0] tr_ms;
        logic tr_trip;
        logic [15:0] blk_ms;
        efc_st_e ie_st;
        logic [15:0] ie_ms;
        logic [3:0] ie_pulses;
        logic ie_trip;
        logic ie_start;
        logic lo_trip;
        logic hi_trip;
        logic [15:0] ev_count;
        logic ev;
    } efc_state_s;
endpackage

// file: efc_core.sv
// Purpose: earth-fault stage coordination
// Assumes: measurement inputs come from another clock and are synchronised here
// Notes: settings are static ports, times in milliseconds
// Operation
// - Calculation window opens one second before operate time
// - Suppress neutral trips during calculation window
// - Current priority: neutral start blocks transient
// - Transient disable leaves intermittent stage working
// - Intermittent start needs pulses, phase, voltage
// - Intermittent trips only with cosine or zero angle
// - Intermittent operation counts transient stage events
// - Direction mismatch blocks transient stage
// - Current priority: neutral start blocks intermittent
// - Intermittent disable switch removes intermittent stage
// - Intermittent trip after six pulses and expiry
// - Rated voltage selects 100 or 110 volts
// - Three control inputs, each own switchgroup
// - Angle input honoured only in compat position
// - Fast switch: low-set off, high-set 0.4 s
// - Full block switch: both blocked about 1 s
`include "efc_regs.svh"
module efc_core (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic voltage_trigger,
    input wire logic residual_voltage_high,
    input wire logic current_pulse,
    input wire logic phase_ok,
    input wire logic transient_forward,
    input wire logic intermittent_forward,
    input wire logic low_set_start,
    input wire logic high_set_start,
    input wire logic low_set_timeout,
    input wire logic high_set_timeout,
    input wire logic external_control_input_one,
    input wire logic external_control_input_two,
    input wire logic external_reset_input,
    input wire logic basic_angle_control_input,
    input wire logic [7:0] sgb_one,
    input wire logic [7:0] sgb_two,
    input wire logic [7:0] sgb_three,
    input wire efc_pkg::efc_ms_t transient_operate_time,
    input wire efc_pkg::efc_ms_t intermittent_operate_time,
    input wire logic cos_characteristic,
    input wire logic zero_basic_angle,
    input wire logic current_priority_switch,
    input wire logic transient_disable_switch,
    input wire logic intermittent_disable_switch,
    input wire logic rated_voltage_select_switch,
    input wire logic angle_input_compat_switch,
    input wire logic fast_transient_switch,
    input wire logic full_block_switch,
    output logic [7:0] rated_voltage,
    output logic basic_angle_alt,
    output logic second_settings,
    output logic reset_indicators,
    output logic reset_outputs,
    output logic reset_registers,
    output logic calc_window,
    output logic transient_start,
    output logic transient_trip,
    output logic intermittent_start,
    output logic intermittent_trip,
    output logic low_set_trip,
    output logic high_set_trip,
    output logic transient_event,
    output logic [15:0] transient_event_count
);
    import efc_pkg::*;

    // Two-flop synchronisers for the asynchronous measurement and control pins
    localparam int NS = 14;
    logic [NS-1:0] raw, s1, s2;
    assign raw = {voltage_trigger, residual_voltage_high, current_pulse, phase_ok,
                  transient_forward, intermittent_forward, low_set_start, high_set_start,
                  low_set_timeout, high_set_timeout, external_control_input_one,
                  external_control_input_two, external_reset_input,
                  basic_angle_control_input};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
        end else begin
            s1 <= raw;
            s2 <= s1;
        end
    end
    logic v_trig, u_high, pulse, ph_ok, tr_fwd, ie_fwd, lo_st, hi_st, lo_to, hi_to;
    logic ctl1, ctl2, ctl3, ang_in, pulse_d;
    assign {v_trig, u_high, pulse, ph_ok, tr_fwd, ie_fwd, lo_st, hi_st, lo_to, hi_to,
            ctl1, ctl2, ctl3, ang_in} = s2;

    // Control inputs: bit0 blocks transient, bit1 intermittent, bit2 neutral stages,
    // bit3 second settings, bit4 basic angle, bits 5-7 reset levels
    // Inputs that share a function are ORed, so any one of them acts
    logic [7:0] act;
    always_comb begin
        act = (ctl1 ? sgb_one : 8'h00) | (ctl2 ? sgb_two : 8'h00)
            | (ctl3 ? sgb_three : 8'h00);
    end
    assign second_settings = act[3];
    assign basic_angle_alt = angle_input_compat_switch & (act[4] | ang_in);
    assign reset_indicators = act[5] | act[6] | act[7];
    assign reset_outputs = act[6] | act[7];
    assign reset_registers = act[7];

    efc_state_s st, next_st;
    logic pulse_rise;
    logic [15:0] win_start;
    logic in_window, tr_block, ie_block, ie_off, nc_block, ie_may_op, neutral_start;
    always_comb begin
        neutral_start = lo_st | hi_st;
        win_start = (transient_operate_time > 16'(`EFC_WINDOW_MS))
                  ? transient_operate_time - 16'(`EFC_WINDOW_MS) : 16'h0000;
        // Window shuts at the operate time so later neutral trips pass again
        in_window = (st.tr_st == EFC_RUN) && (st.tr_ms >= win_start)
                  && (st.tr_ms < transient_operate_time);
        tr_block = transient_disable_switch | act[0]
                 | (current_priority_switch & neutral_start)
                 | (st.ie_start & (ie_fwd != tr_fwd));
        // Disable removes the stage; blocks only hold back its trip
        ie_off = intermittent_disable_switch;
        ie_block = act[1] | (current_priority_switch & neutral_start);
        nc_block = act[2] | in_window
                 | ((st.blk_ms != 16'h0000) & (fast_transient_switch | full_block_switch));
        ie_may_op = cos_characteristic | zero_basic_angle;
    end
    assign pulse_rise = pulse & ~pulse_d;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) pulse_d <= 1'b0;
        else pulse_d <= pulse;
    end

    always_comb begin
        next_st = st;
        next_st.ev = 1'b0;
        // Common millisecond tick; coarser ticks would round short settings away
        next_st.tick = 1'b0;
        if (st.tick_cnt == 18'(`EFC_TICK_CYC - 1)) begin
            next_st.tick_cnt = 18'h0_0000;
            next_st.tick = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 18'h0_0001;
        end
        // Count down first so that a retrigger reloads the full block time
        if (st.tick && st.blk_ms != 16'h0000) begin
            next_st.blk_ms = st.blk_ms - 16'h0001;
        end
        // Transient stage: timing runs regardless of blocks; only the disable switch stops it starting
        case (st.tr_st)
            EFC_IDLE: begin
                if (v_trig && !transient_disable_switch) begin
                    next_st.tr_st = EFC_RUN;
                    next_st.tr_ms = 16'h0000;
                    next_st.blk_ms = full_block_switch ? 16'(`EFC_FULL_BLK_MS)
                                   : 16'(`EFC_FAST_BLK_MS);
                end
            end
            EFC_RUN: begin
                if (st.tick) begin
                    next_st.tr_ms = st.tr_ms + 16'h0001;
                end
                if (st.tr_ms >= transient_operate_time) begin
                    next_st.tr_st = EFC_DONE;
                    if (u_high && !tr_block) begin
                        next_st.tr_trip = 1'b1;
                        next_st.ev = 1'b1;
                    end
                end
            end
            EFC_DONE: begin
                if (!u_high) begin
                    next_st.tr_st = EFC_IDLE;
                    next_st.tr_trip = 1'b0;
                end
            end
            default: next_st.tr_st = EFC_IDLE;
        endcase
        // Intermittent stage
        next_st.ie_start = u_high & ph_ok & (st.ie_pulses != 4'h0) & ~ie_off;
        case (st.ie_st)
            EFC_IDLE: begin
                if (pulse_rise && u_high && ph_ok && !ie_off) begin
                    next_st.ie_st = EFC_RUN;
                    next_st.ie_ms = 16'h0000;
                    next_st.ie_pulses = 4'h1;
                end
            end
            EFC_RUN: begin
                if (!u_high || !ph_ok || ie_off) begin
                    next_st.ie_st = EFC_IDLE;
                    next_st.ie_pulses = 4'h0;
                end else begin
                    if (st.tick && st.ie_ms != 16'hFFFF) begin
                        next_st.ie_ms = st.ie_ms + 16'h0001;
                    end
                    if (pulse_rise && st.ie_pulses != 4'hF) begin
                        next_st.ie_pulses = st.ie_pulses + 4'h1;
                    end
                    if (pulse_rise && st.ie_pulses >= 4'(`EFC_MIN_PULSES - 1)
                        && st.ie_ms >= intermittent_operate_time && ie_may_op
                        && !ie_block) begin
                        next_st.ie_st = EFC_DONE;
                        next_st.ie_trip = 1'b1;
                        next_st.ev = 1'b1;
                    end
                end
            end
            EFC_DONE: begin
                if (!u_high) begin
                    next_st.ie_st = EFC_IDLE;
                    next_st.ie_trip = 1'b0;
                    next_st.ie_pulses = 4'h0;
                end
            end
            default: next_st.ie_st = EFC_IDLE;
        endcase
        // Neutral stages: low-set off entirely while fast mode holds it
        next_st.lo_trip = lo_to & ~nc_block & ~(fast_transient_switch & st.tr_st != EFC_IDLE);
        next_st.hi_trip = hi_to & ~nc_block;
        if (next_st.ev) begin
            next_st.ev_count = st.ev_count + 16'h0001;
        end
        // A register reset outranks an event in the same cycle
        if (act[7]) begin
            next_st.ev_count = 16'h0000;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rated_voltage = rated_voltage_select_switch ? `EFC_UN_HIGH : `EFC_UN_LOW;
    assign calc_window = in_window;
    assign transient_start = (st.tr_st == EFC_RUN);
    assign transient_trip = st.tr_trip;
    assign intermittent_start = st.ie_start;
    assign intermittent_trip = st.ie_trip;
    assign low_set_trip = st.lo_trip;
    assign high_set_trip = st.hi_trip;
    assign transient_event = st.ev;
    assign transient_event_count = st.ev_count;

    a_window_no_trip: assert property (@(posedge clk) disable iff (!rst_n)
        in_window |=> !st.lo_trip && !st.hi_trip) else $error("neutral trip in window");
    a_ie_needs_angle: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(st.ie_trip) |-> $past(ie_may_op)) else $error("intermittent trip bad angle");
    a_ie_disabled: assert property (@(posedge clk) disable iff (!rst_n)
        intermittent_disable_switch |=> !st.ie_start) else $error("intermittent active");
    a_ie_six_pulses: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(st.ie_trip) |-> $past(st.ie_pulses) >= 4'h5) else $error("few pulses");
    a_tr_disabled: assert property (@(posedge clk) disable iff (!rst_n)
        transient_disable_switch |=> !$rose(st.tr_trip)) else $error("transient trip");
    a_ev_counts: assert property (@(posedge clk) disable iff (!rst_n)
        st.ev && !$past(act[7]) |-> st.ev_count != $past(st.ev_count)) else $error("no count");
    a_prio_blocks: assert property (@(posedge clk) disable iff (!rst_n)
        current_priority_switch && neutral_start |=> !$rose(st.tr_trip))
        else $error("priority ignored");
    a_volt_select: assert property (@(posedge clk) disable iff (!rst_n)
        rated_voltage == (rated_voltage_select_switch ? 8'h6E : 8'h64))
        else $error("rated voltage");
    // Neutral-stage blocks: control input and full block hold both trips down one cycle later, fast mode one trip each
    a_neutral_block: assert property (@(posedge clk) disable iff (!rst_n)
        act[2] |=> !st.lo_trip && !st.hi_trip) else $error("control block ignored");
    a_fast_low_off: assert property (@(posedge clk) disable iff (!rst_n)
        fast_transient_switch && (st.tr_st != EFC_IDLE) |=> !st.lo_trip)
        else $error("low-set active in fast mode");
    a_fast_high_block: assert property (@(posedge clk) disable iff (!rst_n)
        fast_transient_switch && (st.blk_ms != 16'h0000) |=> !st.hi_trip)
        else $error("high-set not blocked");
    a_full_block: assert property (@(posedge clk) disable iff (!rst_n)
        full_block_switch && (st.blk_ms != 16'h0000) |=> !st.lo_trip && !st.hi_trip)
        else $error("full block ignored");
    a_window_early: assert property (@(posedge clk) disable iff (!rst_n)
        in_window |-> {1'b0, st.tr_ms} + 17'(`EFC_WINDOW_MS) >= {1'b0, transient_operate_time}
            && st.tr_ms < transient_operate_time) else $error("window misplaced");
    a_ie_start_needs: assert property (@(posedge clk) disable iff (!rst_n)
        st.ie_start |-> $past(u_high) && $past(ph_ok) && ($past(st.ie_pulses) != 4'h0))
        else $error("intermittent start criteria");
    a_ie_prio_block: assert property (@(posedge clk) disable iff (!rst_n)
        current_priority_switch && neutral_start |=> !$rose(st.ie_trip))
        else $error("intermittent priority ignored");
    a_dir_mismatch: assert property (@(posedge clk) disable iff (!rst_n)
        st.ie_start && (ie_fwd != tr_fwd) |=> !$rose(st.tr_trip))
        else $error("direction mismatch ignored");
    a_angle_compat: assert property (@(posedge clk) disable iff (!rst_n)
        !angle_input_compat_switch |-> !basic_angle_alt) else $error("angle input honoured");
    a_ctl_levels: assert property (@(posedge clk) disable iff (!rst_n)
        reset_registers |-> reset_outputs && reset_indicators) else $error("reset levels");
    a_ev_clear: assert property (@(posedge clk) disable iff (!rst_n)
        $past(act[7]) |-> st.ev_count == 16'h0000) else $error("count not cleared");
    c_tr_trip: cover property (@(posedge clk) disable iff (!rst_n) $rose(st.tr_trip));
    c_ie_trip: cover property (@(posedge clk) disable iff (!rst_n) $rose(st.ie_trip));
    c_window: cover property (@(posedge clk) disable iff (!rst_n) $rose(in_window));
    c_ie_blocked: cover property (@(posedge clk) disable iff (!rst_n)
        current_priority_switch && st.ie_start);
    c_full_block: cover property (@(posedge clk) disable iff (!rst_n)
        full_block_switch && (st.blk_ms != 16'h0000));
endmodule

// file: tb_top.sv
// Purpose: self-checking bench for the earth-fault coordination block
// Assumes: 1 ms tick at 250 MHz, so only fast paths fit in a short run
// Notes: each scenario starts from a fresh reset; inputs move on the falling edge
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import efc_pkg::*;
    logic clk, rst_n, vtrig, u0_high, pulse, phase_ok, tr_fwd, ie_fwd;
    logic lo_start, hi_start, lo_to, hi_to, angle_in;
    logic [2:0] ctl;
    logic [7:0] control_input_switchgroup [3];
    efc_ms_t tr_time, ie_time;
    logic cos_c, zero_a, prio_sw, tr_dis, ie_dis, volt_sel, compat, fast_sw, full_sw;
    logic [7:0] rated;
    logic angle_alt, second, rst_ind, rst_out, rst_reg, win, tr_start, tr_trip;
    logic ie_start, ie_trip, lo_trip, hi_trip, tr_ev;
    logic [15:0] ev_cnt;
    int miscompares = 0;
    int num_checks = 0;

    efc_core dut (.clk(clk), .rst_n(rst_n), .voltage_trigger(vtrig),
        .residual_voltage_high(u0_high), .current_pulse(pulse), .phase_ok(phase_ok),
        .transient_forward(tr_fwd), .intermittent_forward(ie_fwd),
        .low_set_start(lo_start), .high_set_start(hi_start), .low_set_timeout(lo_to),
        .high_set_timeout(hi_to), .external_control_input_one(ctl[0]),
        .external_control_input_two(ctl[1]), .external_reset_input(ctl[2]),
        .basic_angle_control_input(angle_in), .sgb_one(control_input_switchgroup[0]), .sgb_two(control_input_switchgroup[1]),
        .sgb_three(control_input_switchgroup[2]), .transient_operate_time(tr_time),
        .intermittent_operate_time(ie_time), .cos_characteristic(cos_c),
        .zero_basic_angle(zero_a), .current_priority_switch(prio_sw),
        .transient_disable_switch(tr_dis), .intermittent_disable_switch(ie_dis),
        .rated_voltage_select_switch(volt_sel), .angle_input_compat_switch(compat),
        .fast_transient_switch(fast_sw), .full_block_switch(full_sw),
        .rated_voltage(rated), .basic_angle_alt(angle_alt), .second_settings(second),
        .reset_indicators(rst_ind), .reset_outputs(rst_out), .reset_registers(rst_reg),
        .calc_window(win), .transient_start(tr_start), .transient_trip(tr_trip),
        .intermittent_start(ie_start), .intermittent_trip(ie_trip),
        .low_set_trip(lo_trip), .high_set_trip(hi_trip), .transient_event(tr_ev),
        .transient_event_count(ev_cnt));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic close_out();
        if (miscompares == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chb(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic idle();
        {vtrig, u0_high, pulse, phase_ok, tr_fwd, ie_fwd, angle_in} = 7'h00;
        {lo_start, hi_start, lo_to, hi_to, ctl} = 7'h00;
        {cos_c, zero_a, prio_sw, tr_dis, ie_dis, volt_sel, compat, fast_sw, full_sw} = 9'h000;
        control_input_switchgroup = '{8'h00, 8'h00, 8'h00};
        tr_time = 16'h01F4;
        ie_time = 16'h0000;
    endtask

    // Reset held four cycles so every scenario starts from the same state
    task automatic do_reset();
        rst_n = 1'b0;
        idle();
        cyc(4);
        rst_n = 1'b1;
        cyc(1);
        chb(ie_trip, 1'b0);
        chk(ev_cnt, 16'h0000);
    endtask

    // Each pulse spans several cycles so the synchroniser cannot swallow it
    task automatic pulses(input int n);
        repeat (n) begin
            pulse = 1'b1;
            cyc(3);
            pulse = 1'b0;
            cyc(3);
        end
    endtask

    task automatic s_volt();
        do_reset();
        cyc(1);
        chk({8'h00, rated}, 16'h0064);
        volt_sel = 1'b1;
        cyc(1);
        chk({8'h00, rated}, 16'h006E);
    endtask

    task automatic s_ctl();
        do_reset();
        angle_in = 1'b1;
        compat = 1'b1;
        cyc(4);
        chb(angle_alt, 1'b1);
        compat = 1'b0;
        cyc(1);
        chb(angle_alt, 1'b0);
        for (int i = 0; i < 3; i++) begin
            do_reset();
            control_input_switchgroup[i] = 8'h28;
            ctl[i] = 1'b1;
            cyc(4);
            chk({12'h000, second, rst_ind, rst_out, rst_reg}, 16'h000C);
            control_input_switchgroup[i] = 8'hC0;
            cyc(1);
            chk({12'h000, second, rst_ind, rst_out, rst_reg}, 16'h0007);
        end
    endtask

    task automatic ie_run(input logic c, input logic z, input logic pr, input logic dis);
        do_reset();
        {cos_c, zero_a, prio_sw, ie_dis} = {c, z, pr, dis};
        lo_start = pr;
        {phase_ok, u0_high, tr_fwd, ie_fwd} = 4'hF;
        cyc(4);
        chb(ie_start, 1'b0);
        pulses(5);
        chb(ie_trip, 1'b0);
        pulses(1);
    endtask

    task automatic s_inter();
        ie_run(1'b0, 1'b0, 1'b0, 1'b0);
        chb(ie_start, 1'b1);
        chb(ie_trip, 1'b0);
        phase_ok = 1'b0;
        cyc(4);
        chb(ie_start, 1'b0);
        ie_run(1'b1, 1'b0, 1'b0, 1'b0);
        chb(ie_trip, 1'b1);
        chk(ev_cnt, 16'h0001);
        control_input_switchgroup[1] = 8'h80;
        ctl[1] = 1'b1;
        cyc(4);
        chk(ev_cnt, 16'h0000);
        ie_run(1'b0, 1'b1, 1'b1, 1'b0);
        chb(ie_start, 1'b1);
        chb(ie_trip, 1'b0);
        ie_run(1'b1, 1'b0, 1'b0, 1'b1);
        chk({14'h0000, ie_start, ie_trip}, 16'h0000);
    endtask

    // Zero operate time lets the transient stage operate inside a short run
    task automatic tr_fire(input logic pr, input logic exp_trip);
        do_reset();
        tr_time = 16'h0000;
        {prio_sw, lo_start, u0_high, vtrig} = {pr, pr, 2'b11};
        cyc(2);
        vtrig = 1'b0;
        cyc(2);
        chb(tr_trip, exp_trip);
        chb(tr_ev, exp_trip);
        chk(ev_cnt, {15'h0000, exp_trip});
        cyc(1);
        chb(tr_ev, 1'b0);
        chb(win, 1'b0);
        u0_high = 1'b0;
        cyc(4);
        chb(tr_trip, 1'b0);
    endtask

    // Long operate time keeps the window shut, so only the switch blocks act
    task automatic tr_block_run(input logic fs, input logic fb, input logic [15:0] exp);
        do_reset();
        tr_time = 16'h2710;
        {fast_sw, full_sw} = {fs, fb};
        {lo_start, lo_to, hi_start, hi_to, u0_high, vtrig} = 6'h3F;
        cyc(2);
        vtrig = 1'b0;
        cyc(4);
        chb(win, 1'b0);
        chb(tr_start, 1'b1);
        chk({14'h0000, lo_trip, hi_trip}, exp);
    endtask

    task automatic s_trans();
        do_reset();
        {lo_start, lo_to, hi_start, hi_to, u0_high} = 5'h1F;
        cyc(5);
        chk({14'h0000, lo_trip, hi_trip}, 16'h0003);
        do_reset();
        tr_dis = 1'b1;
        vtrig = 1'b1;
        cyc(2);
        vtrig = 1'b0;
        cyc(4);
        chb(tr_start, 1'b0);
        do_reset();
        {lo_start, lo_to, u0_high, vtrig} = 4'hF;
        cyc(2);
        vtrig = 1'b0;
        cyc(4);
        chb(tr_start, 1'b1);
        chb(win, 1'b1);
        chb(lo_trip, 1'b0);
        tr_fire(1'b0, 1'b1);
        tr_fire(1'b1, 1'b0);
        tr_block_run(1'b0, 1'b0, 16'h0003);
        tr_block_run(1'b1, 1'b0, 16'h0000);
        tr_block_run(1'b0, 1'b1, 16'h0000);
    endtask

    initial begin
        repeat (50000) @(posedge clk);
        miscompares++;
        close_out();
    end

    initial begin
        rst_n = 1'b0;
        idle();
        s_volt();
        s_ctl();
        s_inter();
        s_trans();
        close_out();
    end
endmodule
